// [src/gpio_pkg.sv]
// Package: register map, field layouts and carriers for the shared-pin GPIO block
package gpio_pkg;

	// ****************************************
	// Register indexes and byte offsets
	// ****************************************
	// One aligned word per register: byte offset is four times the index
	localparam logic [7:0] port_b_data_idx   = 8'h01;
	localparam logic [7:0] port_c_data_idx   = 8'h02;
	localparam logic [7:0] port_d_data_idx   = 8'h03;
	localparam logic [7:0] port_b_dir_idx    = 8'h04;
	localparam logic [7:0] port_c_dir_idx    = 8'h05;
	localparam logic [7:0] port_d_dir_idx    = 8'h06;
	localparam logic [7:0] port_a_dir_idx    = 8'h09;
	localparam logic [7:0] periph_ctrl_idx   = 8'h0A;
	localparam logic [7:0] analog_chan_idx   = 8'h0B;
	localparam logic [7:0] port_a_pue_idx    = 8'h0D;
	localparam logic [7:0] port_c_pue_idx    = 8'h0E;
	localparam logic [7:0] port_b_data_off   = port_b_data_idx * 8'h04;
	localparam logic [7:0] port_c_data_off   = port_c_data_idx * 8'h04;
	localparam logic [7:0] port_d_data_off   = port_d_data_idx * 8'h04;
	localparam logic [7:0] port_b_dir_off    = port_b_dir_idx * 8'h04;
	localparam logic [7:0] port_c_dir_off    = port_c_dir_idx * 8'h04;
	localparam logic [7:0] port_d_dir_off    = port_d_dir_idx * 8'h04;
	localparam logic [7:0] port_a_pue_off    = port_a_pue_idx * 8'h04;
	localparam logic [7:0] port_c_pue_off    = port_c_pue_idx * 8'h04;
	localparam logic [7:0] port_a_dir_off    = port_a_dir_idx * 8'h04;
	localparam logic [7:0] periph_ctrl_off   = periph_ctrl_idx * 8'h04;
	localparam logic [7:0] analog_chan_off   = analog_chan_idx * 8'h04;

	// ****************************************
	// Field layouts and reset values
	// ****************************************
	localparam int          port_c_width     = 7;
	localparam logic [7:0]  port_c_mask      = 8'h7F;
	localparam logic [7:0]  dir_reset        = 8'h00;
	localparam logic [7:0]  pue_reset        = 8'h00;
	localparam int          ctrl_spi_en_pos  = 0;
	localparam int          ctrl_spi_mst_pos = 1;
	localparam int          ctrl_els_pos     = 2;
	localparam logic [9:0]  ctrl_reset       = 10'h000;
	localparam int          chan_en_pos      = 3;
	localparam logic [3:0]  chan_reset       = 4'h0;
	localparam int          spi_ss_bit       = 0;
	localparam int          spi_miso_bit     = 1;
	localparam int          spi_mosi_bit     = 2;
	localparam int          spi_clk_bit      = 3;
	localparam int          timer_pin_base   = 4;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic [7:0] dout;
		logic [7:0] oe;
	} pin_drive_t;

	typedef struct packed {
		logic [3:0] oe;
		logic [3:0] dout;
	} periph_drive_t;

endpackage

// [src/shared_pin_gpio_ports.sv]
// Shared-pin GPIO logic for ports A (pullups), B, C and D with APB register access
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
// Notes on behaviour
// RULE1 - Pullups act only on input pins
// RULE2 - Pullup bit one connects, zero disconnects
// RULE3 - Selected analog channel forces its pin input
// RULE4 - Reset leaves data latches untouched
// RULE5 - Direction one drives pin, zero makes input
// RULE6 - Reset clears port B and C direction
// RULE7 - Output pins read back their latch
// RULE8 - Input pins read sampled pin level
// RULE9 - Latch writes accepted regardless of direction
// RULE10 - Input pin write changes latch only
// RULE11 - Port C seven pins, address after B
// RULE12 - Port D shares SPI and timer pins
// RULE13 - Edge/level select gives pin to timer
// RULE14 - SPI disabled returns SPI pins to GPIO
// RULE15 - SPI pins ignore direction, reads still use it
// RULE16 - Software writes latch before setting direction
// RULE17 - Slave select free when SPI off or master
// RULE18 - Owning peripheral drives pin enable and value
module shared_pin_gpio_ports (
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [7:0]               paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire logic [7:0]               port_b_pin_in,
	input  wire logic [6:0]               port_c_pin_in,
	input  wire logic [7:0]               port_d_pin_in,
	input  wire gpio_pkg::periph_drive_t  spi_drive,
	input  wire gpio_pkg::periph_drive_t  timer_drive,
	output gpio_pkg::pin_drive_t          port_b_drive,
	output gpio_pkg::pin_drive_t          port_c_drive,
	output gpio_pkg::pin_drive_t          port_d_drive,
	output logic      [7:0]               port_a_pullup,
	output logic      [6:0]               port_c_pullup,
	output logic      [7:0]               analog_select,
	output logic      [7:0]               port_d_sync
);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [7:0] b_level;
	logic [6:0] c_level;
	logic [7:0] d_level;

	pin_synchroniser #(
		.width(8)
	) sync_b (
		.pclk(pclk),
		.presetn(presetn),
		.pin_in(port_b_pin_in),
		.pin_level(b_level)
	);

	pin_synchroniser #(
		.width(7)
	) sync_c (
		.pclk(pclk),
		.presetn(presetn),
		.pin_in(port_c_pin_in),
		.pin_level(c_level)
	);

	pin_synchroniser #(
		.width(8)
	) sync_d (
		.pclk(pclk),
		.presetn(presetn),
		.pin_in(port_d_pin_in),
		.pin_level(d_level)
	);

	// ****************************************
	// Data latches, no reset
	// ****************************************
	logic [7:0] port_b_data_latch;
	logic [6:0] port_c_data_latch;
	logic [7:0] port_d_data_latch;
	logic [7:0] next_port_b_data_latch;
	logic [6:0] next_port_c_data_latch;
	logic [7:0] next_port_d_data_latch;

	wire logic wr_en = psel && penable && pwrite;

	always_comb begin
		next_port_b_data_latch = port_b_data_latch;
		next_port_c_data_latch = port_c_data_latch;
		next_port_d_data_latch = port_d_data_latch;
		if (wr_en) begin
			case (paddr)
				gpio_pkg::port_b_data_off: next_port_b_data_latch = pwdata[7:0]; // RULE9 RULE10
				gpio_pkg::port_c_data_off: next_port_c_data_latch = pwdata[6:0]; // RULE9 RULE10
				gpio_pkg::port_d_data_off: next_port_d_data_latch = pwdata[7:0]; // RULE9 RULE10
				default: ;
			endcase
		end
	end

	// Latches keep power-up contents; reset does not touch them
	always_ff @(posedge pclk) begin
		port_b_data_latch <= next_port_b_data_latch; // RULE4
		port_c_data_latch <= next_port_c_data_latch; // RULE4
		port_d_data_latch <= next_port_d_data_latch; // RULE4
	end

	// ****************************************
	// Control registers
	// ****************************************
	logic [7:0] port_a_direction;
	logic [7:0] port_b_direction;
	logic [6:0] port_c_direction;
	logic [7:0] port_d_direction;
	logic [7:0] port_a_pullup_enable;
	logic [6:0] port_c_pullup_enable;
	logic [9:0] periph_ctrl;
	logic [3:0] analog_chan;
	logic [7:0] next_port_a_direction;
	logic [7:0] next_port_b_direction;
	logic [6:0] next_port_c_direction;
	logic [7:0] next_port_d_direction;
	logic [7:0] next_port_a_pullup_enable;
	logic [6:0] next_port_c_pullup_enable;
	logic [9:0] next_periph_ctrl;
	logic [3:0] next_analog_chan;

	always_comb begin
		next_port_a_direction     = port_a_direction;
		next_port_b_direction     = port_b_direction;
		next_port_c_direction     = port_c_direction;
		next_port_d_direction     = port_d_direction;
		next_port_a_pullup_enable = port_a_pullup_enable;
		next_port_c_pullup_enable = port_c_pullup_enable;
		next_periph_ctrl          = periph_ctrl;
		next_analog_chan          = analog_chan;
		if (wr_en) begin
			case (paddr)
				gpio_pkg::port_a_dir_off: next_port_a_direction     = pwdata[7:0];
				gpio_pkg::port_b_dir_off: next_port_b_direction     = pwdata[7:0];
				gpio_pkg::port_c_dir_off: next_port_c_direction     = pwdata[6:0];
				gpio_pkg::port_d_dir_off: next_port_d_direction     = pwdata[7:0];
				gpio_pkg::port_a_pue_off: next_port_a_pullup_enable = pwdata[7:0];
				gpio_pkg::port_c_pue_off: next_port_c_pullup_enable = pwdata[6:0];
				gpio_pkg::periph_ctrl_off: next_periph_ctrl         = pwdata[9:0];
				gpio_pkg::analog_chan_off: next_analog_chan         = pwdata[3:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_a_direction     <= gpio_pkg::dir_reset;
			port_b_direction     <= gpio_pkg::dir_reset; // RULE6
			port_c_direction     <= gpio_pkg::dir_reset[6:0]; // RULE6
			port_d_direction     <= gpio_pkg::dir_reset;
			port_a_pullup_enable <= gpio_pkg::pue_reset;
			port_c_pullup_enable <= gpio_pkg::pue_reset[6:0];
			periph_ctrl          <= gpio_pkg::ctrl_reset;
			analog_chan          <= gpio_pkg::chan_reset;
		end else begin
			port_a_direction     <= next_port_a_direction;
			port_b_direction     <= next_port_b_direction;
			port_c_direction     <= next_port_c_direction;
			port_d_direction     <= next_port_d_direction;
			port_a_pullup_enable <= next_port_a_pullup_enable;
			port_c_pullup_enable <= next_port_c_pullup_enable;
			periph_ctrl          <= next_periph_ctrl;
			analog_chan          <= next_analog_chan;
		end
	end

	// ****************************************
	// Pin ownership
	// ****************************************
	wire logic       spi_enable_bit        = periph_ctrl[gpio_pkg::ctrl_spi_en_pos];
	wire logic       spi_master_select_bit = periph_ctrl[gpio_pkg::ctrl_spi_mst_pos];
	wire logic [7:0] timer_edge_level_select = periph_ctrl[gpio_pkg::ctrl_els_pos +: 8];

	logic [7:0] d_owned;
	logic [7:0] d_periph_oe;
	logic [7:0] d_periph_out;
	logic [7:0] b_analog;

	always_comb begin
		d_owned = 8'h00;
		d_owned[gpio_pkg::spi_ss_bit]   = spi_enable_bit && !spi_master_select_bit; // RULE17
		d_owned[gpio_pkg::spi_miso_bit] = spi_enable_bit; // RULE14
		d_owned[gpio_pkg::spi_mosi_bit] = spi_enable_bit; // RULE14
		d_owned[gpio_pkg::spi_clk_bit]  = spi_enable_bit; // RULE14
		for (int i = 0; i < 4; i++) begin
			// Field 00 leaves the pin to the port
			d_owned[gpio_pkg::timer_pin_base + i] = |timer_edge_level_select[2*i +: 2]; // RULE12 RULE13
		end
		d_periph_oe  = {timer_drive.oe, spi_drive.oe};
		d_periph_out = {timer_drive.dout, spi_drive.dout};
		b_analog = 8'h00;
		if (analog_chan[gpio_pkg::chan_en_pos]) begin
			b_analog[analog_chan[2:0]] = 1'b1; // RULE3
		end
	end

	// ****************************************
	// Pin drive, registered
	// ****************************************
	gpio_pkg::pin_drive_t next_port_b_drive;
	gpio_pkg::pin_drive_t next_port_c_drive;
	gpio_pkg::pin_drive_t next_port_d_drive;
	logic [7:0]           next_port_a_pullup;
	logic [6:0]           next_port_c_pullup;

	always_comb begin
		next_port_b_drive.dout = port_b_data_latch;
		next_port_b_drive.oe   = port_b_direction & ~b_analog; // RULE3 RULE5
		next_port_c_drive.dout = {1'b0, port_c_data_latch};
		next_port_c_drive.oe   = {1'b0, port_c_direction}; // RULE5 RULE11
		for (int i = 0; i < 8; i++) begin
			next_port_d_drive.dout[i] = d_owned[i] ? d_periph_out[i] : port_d_data_latch[i]; // RULE18
			next_port_d_drive.oe[i]   = d_owned[i] ? d_periph_oe[i] : port_d_direction[i]; // RULE15 RULE18
		end
		next_port_a_pullup = port_a_pullup_enable & ~port_a_direction; // RULE1 RULE2
		next_port_c_pullup = port_c_pullup_enable & ~port_c_direction; // RULE1 RULE2
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_b_drive  <= '0;
			port_c_drive  <= '0;
			port_d_drive  <= '0;
			port_a_pullup <= '0;
			port_c_pullup <= '0;
			analog_select <= '0;
			port_d_sync   <= '0;
		end else begin
			port_b_drive  <= next_port_b_drive;
			port_c_drive  <= next_port_c_drive;
			port_d_drive  <= next_port_d_drive;
			port_a_pullup <= next_port_a_pullup;
			port_c_pullup <= next_port_c_pullup;
			analog_select <= b_analog;
			// Peripherals see the synchronised level of their own pins
			port_d_sync   <= d_level;
		end
	end

	// ****************************************
	// APB read path
	// ****************************************
	logic [7:0] b_read;
	logic [6:0] c_read;
	logic [7:0] d_read;

	dir_read_select #(
		.width(8)
	) read_b (
		.direction(port_b_direction),
		.latch(port_b_data_latch),
		.level(b_level),
		.read_value(b_read)
	);

	dir_read_select #(
		.width(7)
	) read_c (
		.direction(port_c_direction),
		.latch(port_c_data_latch),
		.level(c_level),
		.read_value(c_read)
	);

	dir_read_select #(
		.width(8)
	) read_d (
		.direction(port_d_direction),
		.latch(port_d_data_latch),
		.level(d_level),
		.read_value(d_read)
	);

	logic [31:0] next_prdata;
	logic        next_pslverr;
	logic        known;

	// Reads use the direction bit even for pins a peripheral owns
	always_comb begin
		next_prdata  = 32'h0000_0000;
		known        = 1'b1;
		case (paddr)
			gpio_pkg::port_b_data_off: next_prdata[7:0] = b_read; // RULE7 RULE8
			gpio_pkg::port_c_data_off: next_prdata[6:0] = c_read; // RULE7 RULE8 RULE11
			gpio_pkg::port_d_data_off: next_prdata[7:0] = d_read; // RULE15
			gpio_pkg::port_a_dir_off: next_prdata[7:0] = port_a_direction;
			gpio_pkg::port_b_dir_off: next_prdata[7:0] = port_b_direction;
			gpio_pkg::port_c_dir_off: next_prdata[6:0] = port_c_direction;
			gpio_pkg::port_d_dir_off: next_prdata[7:0] = port_d_direction;
			gpio_pkg::port_a_pue_off: next_prdata[7:0] = port_a_pullup_enable;
			gpio_pkg::port_c_pue_off: next_prdata[6:0] = port_c_pullup_enable;
			gpio_pkg::periph_ctrl_off: next_prdata[9:0] = periph_ctrl;
			gpio_pkg::analog_chan_off: next_prdata[3:0] = analog_chan;
			default: known = 1'b0;
		endcase
		if (!(psel && !penable) || pwrite) begin
			next_prdata = prdata;
		end
		next_pslverr = psel && !penable && !known;
	end

	// One wait-free access: data captured in setup, presented in access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= '0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata  <= next_prdata;
			pready  <= psel && !penable;
			pslverr <= next_pslverr;
		end
	end

endmodule

// ****************************************
// Two-flop pin synchroniser
// ****************************************
// Only the second stage is read; the first may still be settling
module pin_synchroniser #(
	parameter int width = 8
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [width-1:0] pin_in,
	output logic      [width-1:0] pin_level
);

	logic [width-1:0] meta;
	logic [width-1:0] next_meta;
	logic [width-1:0] next_pin_level;

	always_comb begin
		next_meta      = pin_in;
		next_pin_level = meta;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta      <= '0;
			pin_level <= '0;
		end else begin
			meta      <= next_meta;
			pin_level <= next_pin_level;
		end
	end

endmodule

// ****************************************
// Direction-steered read selector
// ****************************************
// Output pins give back the latch, input pins the synchronised level
module dir_read_select #(
	parameter int width = 8
) (
	input  wire logic [width-1:0] direction,
	input  wire logic [width-1:0] latch,
	input  wire logic [width-1:0] level,
	output logic      [width-1:0] read_value
);

	always_comb begin
		read_value = (direction & latch) | (~direction & level); // RULE7 RULE8
	end

endmodule

// [dv/gpio_props.sv]
// Checker bound to the shared-pin GPIO block
`timescale 1ns/1ps
module gpio_props (
	input wire logic                 pclk,
	input wire logic                 presetn,
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pwrite,
	input wire logic [31:0]          prdata,
	input wire logic                 pready,
	input wire logic                 pslverr,
	input wire logic [7:0]           port_d_pin_in,
	input wire gpio_pkg::pin_drive_t port_b_drive,
	input wire gpio_pkg::pin_drive_t port_c_drive,
	input wire logic [6:0]           port_c_pullup,
	input wire logic [7:0]           analog_select,
	input wire logic [7:0]           port_d_sync
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Sync chain shows reset zeros for three edges
	logic [1:0] age;
	logic [1:0] next_age;
	always_comb next_age = (age == 2'h3) ? age : age + 2'h1;
	always_ff @(posedge pclk or negedge presetn) if (!presetn) age <= 2'h0; else age <= next_age;
	a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready after setup");
	a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held too long");
	a_ready_needs_sel: assert property (!psel |=> !pready) else $error("ready without select");
	a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
	a_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("refused read data");
	a_pullup_input_only: assert property ((port_c_pullup & port_c_drive.oe[6:0]) == 7'h00)
		else $error("pullup on output pin");
	a_analog_pin_input: assert property ((port_b_drive.oe & analog_select) == 8'h00)
		else $error("analog pin driven");
	a_c_top_idle: assert property (port_c_drive.oe[7] == 1'b0 && port_c_drive.dout[7] == 1'b0)
		else $error("port C bit seven driven");
	a_sync_delay: assert property (age == 2'h3 |-> port_d_sync == $past(port_d_pin_in, 3))
		else $error("sync latency wrong");
	c_refused: cover property (pready && pslverr);
	c_analog: cover property (analog_select != 8'h00);
	c_pullup: cover property (port_c_pullup != 7'h00);
endmodule
bind shared_pin_gpio_ports gpio_props chk (.pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
	.port_d_pin_in, .port_b_drive, .port_c_drive, .port_c_pullup, .analog_select, .port_d_sync);

// [dv/pin_world.sv]
// Pin-side model: outside circuitry meets the block's output buffers
`timescale 1ns/1ps
module pin_world (
	input wire gpio_pkg::pin_drive_t b_drv,
	input wire gpio_pkg::pin_drive_t c_drv,
	input wire gpio_pkg::pin_drive_t d_drv,
	input wire logic [23:0]          ext,
	output logic [7:0]               b_pin,
	output logic [6:0]               c_pin,
	output logic [7:0]               d_pin
);
	// Undriven pins follow an outside pattern the bench changes in every port check
	assign b_pin = (b_drv.oe & b_drv.dout) | (~b_drv.oe & ext[7:0]);
	assign c_pin = (c_drv.oe[6:0] & c_drv.dout[6:0]) | (~c_drv.oe[6:0] & ext[14:8]);
	assign d_pin = (d_drv.oe & d_drv.dout) | (~d_drv.oe & ext[23:16]);
endmodule

// [dv/shared_pin_gpio_ports_tb_top.sv]
// Self-checking bench for the shared-pin GPIO block
`timescale 1ns/1ps
`define CHK(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin err_total++; \
	$display("MISMATCH %s exp %0h got %0h", nm, e, s); end end
module shared_pin_gpio_ports_tb_top;
	logic                    pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
	logic [7:0]              paddr = 8'h00, b_pin, d_pin, port_a_pullup, analog_select, port_d_sync;
	logic [31:0]             pwdata = 32'h0, prdata, rd, seed = 32'h32EB;
	logic [23:0]             ext = 24'h0;
	logic [6:0]              c_pin, port_c_pullup;
	logic                    pready, pslverr;
	gpio_pkg::periph_drive_t spi_drive = '0, timer_drive = '0;
	gpio_pkg::pin_drive_t    port_b_drive, port_c_drive, port_d_drive;
	int                      err_total = 0, samples_checked = 0, k;
	shared_pin_gpio_ports dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.port_b_pin_in(b_pin), .port_c_pin_in(c_pin), .port_d_pin_in(d_pin), .spi_drive, .timer_drive,
		.port_b_drive, .port_c_drive, .port_d_drive, .port_a_pullup, .port_c_pullup, .analog_select, .port_d_sync);
	pin_world pins (.b_drv(port_b_drive), .c_drv(port_c_drive), .d_drv(port_d_drive), .ext, .b_pin, .c_pin, .d_pin);
	always #25 pclk = ~pclk;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		for (int i = 0; i < 32; i++) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
		return s;
	endfunction
	function automatic logic [7:0] mix(input logic [7:0] a, input logic [7:0] sel, input logic [7:0] b);
		return (a & sel) | (b & ~sel);
	endfunction
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
		if (n >= 50) err_total++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic port_chk(input logic [7:0] da, input logic [7:0] ra, input logic [7:0] m, input int p);
		logic [7:0] oe;
		logic [7:0] dq;
		seed = lfsr(seed);
		ext[p*8+:8] <= seed[23:16];
		// Latch first so the pin never shows stale data
		apb(1'b1, da, {24'h0, seed[7:0]});
		apb(1'b1, ra, {24'h0, seed[15:8]});
		repeat (3) @(posedge pclk);
		apb(1'b0, da, 32'h0);
		`CHK("port read", {24'h0, mix(seed[7:0], seed[15:8], seed[23:16]) & m}, rd)
		oe = (p == 0) ? port_b_drive.oe : (p == 1) ? port_c_drive.oe : port_d_drive.oe;
		dq = (p == 0) ? port_b_drive.dout : (p == 1) ? port_c_drive.dout : port_d_drive.dout;
		`CHK("pin oe", seed[15:8] & m, oe)
		`CHK("pin out", seed[7:0] & m, dq)
	endtask
	task automatic periph_chk(input logic [31:0] ctrl, input logic [7:0] oe, input logic [7:0] dq, input logic [7:0] dr);
		apb(1'b1, gpio_pkg::periph_ctrl_off, ctrl);
		repeat (3) @(posedge pclk);
		`CHK("d oe", oe, port_d_drive.oe)
		`CHK("d out", dq, port_d_drive.dout)
		apb(1'b0, gpio_pkg::port_d_data_off, 32'h0);
		`CHK("d read", {24'h0, mix(~seed[7:0], dr, mix(dq, oe, ext[23:16]))}, rd)
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge pclk);
		err_total++;
		end_of_test();
	end
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, gpio_pkg::port_b_dir_off, 32'h0);
		`CHK("b dir reset", 32'h0, rd)
		apb(1'b0, gpio_pkg::port_c_dir_off, 32'h0);
		`CHK("c dir reset", 32'h0, rd)
		for (k = 0; k < 20; k++) begin
			port_chk(gpio_pkg::port_b_data_off, gpio_pkg::port_b_dir_off, 8'hFF, 0);
			port_chk(gpio_pkg::port_c_data_off, gpio_pkg::port_c_dir_off, gpio_pkg::port_c_mask, 1);
			port_chk(gpio_pkg::port_d_data_off, gpio_pkg::port_d_dir_off, 8'hFF, 2);
		end
		$display("port test done");
		for (k = 0; k < 8; k++) begin
			seed = lfsr(seed);
			apb(1'b1, gpio_pkg::port_c_pue_off, {24'h0, seed[7:0]});
			apb(1'b1, gpio_pkg::port_c_dir_off, {24'h0, seed[15:8]});
			apb(1'b1, gpio_pkg::port_a_pue_off, {24'h0, seed[23:16]});
			apb(1'b1, gpio_pkg::port_a_dir_off, {24'h0, seed[31:24]});
			repeat (2) @(posedge pclk);
			`CHK("c pullup", seed[6:0] & ~seed[14:8], port_c_pullup)
			`CHK("a pullup", seed[23:16] & ~seed[31:24], port_a_pullup)
		end
		$display("pullup test done");
		apb(1'b1, gpio_pkg::port_b_dir_off, 32'hFF);
		for (k = 0; k < 8; k++) begin
			apb(1'b1, gpio_pkg::analog_chan_off, 32'h8 | k);
			repeat (2) @(posedge pclk);
			`CHK("analog sel", 8'h01 << k, analog_select)
			`CHK("analog oe", ~(8'h01 << k), port_b_drive.oe)
		end
		apb(1'b1, gpio_pkg::analog_chan_off, 32'h5);
		repeat (2) @(posedge pclk);
		`CHK("analog off", 8'h00, analog_select)
		$display("analog test done");
		seed = lfsr(seed);
		spi_drive <= seed[7:0];
		timer_drive <= seed[15:8];
		apb(1'b1, gpio_pkg::port_d_data_off, {24'h0, ~seed[7:0]});
		apb(1'b1, gpio_pkg::port_d_dir_off, 32'h0);
		periph_chk(32'h155, {seed[15:12], seed[7:4]}, {seed[11:8], seed[3:0]}, 8'h00);
		apb(1'b1, gpio_pkg::port_d_dir_off, 32'hFF);
		periph_chk(32'h155, {seed[15:12], seed[7:4]}, {seed[11:8], seed[3:0]}, 8'hFF);
		periph_chk(32'h157, {seed[15:12], seed[7:5], 1'b1}, {seed[11:8], seed[3:1], ~seed[0]}, 8'hFF);
		periph_chk(32'hE3, {1'b1, seed[14:13], 1'b1, seed[7:5], 1'b1},
			{~seed[7], seed[10:9], ~seed[4], seed[3:1], ~seed[0]}, 8'hFF);
		periph_chk(32'h0, 8'hFF, ~seed[7:0], 8'hFF);
		$display("peripheral test done");
		apb(1'b0, 8'h40, 32'h0);
		`CHK("bad read err", 1'b1, err)
		`CHK("bad read data", 32'h0, rd)
		apb(1'b1, 8'h40, 32'h5A);
		`CHK("bad write err", 1'b1, err)
		apb(1'b1, gpio_pkg::port_b_data_off, 32'hA5);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, gpio_pkg::port_b_dir_off, 32'h0);
		`CHK("dir after reset", 32'h0, rd)
		apb(1'b1, gpio_pkg::port_b_dir_off, 32'hFF);
		apb(1'b0, gpio_pkg::port_b_data_off, 32'h0);
		`CHK("latch kept", 32'hA5, rd)
		$display("refusal and reset test done");
		end_of_test();
	end
endmodule
